// >>> hw/rpps_pkg.sv
// Package of constants for the receive-port page select and status block.
`default_nettype none

package rpps_pkg;
	// ****************************************************************
	// Register offsets.
	// ****************************************************************
	localparam logic [7:0] PAGE_SELECT_ADDR = 8'h4c; // Port-select register.
	localparam logic [7:0] STATUS_ONE_ADDR  = 8'h4d; // Per-port status register.
	localparam logic [7:0] PAGED_REG_ADDR   = 8'h60; // Example paged register.

	// ****************************************************************
	// Field positions and reset values.
	// ****************************************************************
	localparam int PHYS_PORT_LSB = 6; // Physical port number field.
	localparam int READ_PORT_LSB = 4; // Read-port field.
	localparam int CRC_BIT       = 5; // Control channel CRC error.
	localparam int LCHG_BIT      = 4; // Lock change flag.
	localparam int SEQ_BIT       = 3; // Control channel sequence error.
	localparam int PAR_BIT       = 2; // Parity threshold flag.
	localparam int PASS_BIT      = 1; // Live pass indication.
	localparam int LOCK_BIT      = 0; // Live lock indication.
	localparam logic [7:0] STATUS_RESET = 8'h00; // Status reset value.
	localparam logic [7:0] PAGED_RESET  = 8'h00; // Paged register reset value.
	localparam int NUM_PORTS = 4; // Receive ports.
endpackage : rpps_pkg

`default_nettype wire

// >>> hw/rpps_top.sv
// Port page select and per-port status register bank.
//
// Function
// - Physical port reads zero locally, else arrival port.
// - Read-port field picks paged block for readback.
// - Read-port defaults zero locally, else arrival port.
// - Write-enable bits gate writes per port, combinable.
// - Write-enables default zero; arrival port's one remotely.
// - Status port field reflects selected read port.
// - CRC error sticky until status read.
// - Lock change sticky until status read.
// - Sequence error sticky until status read.
// - Parity flag over threshold; clears on count clear/read.
// - Pass bit shows live pass criteria.
// - Lock bit shows live lock state.
`timescale 1ns/1ps
`default_nettype none

module rpps_top #(
	parameter int PORTS = rpps_pkg::NUM_PORTS // Receive port count.
) (
	input  wire logic             clk,          // 40 MHz register clock.
	input  wire logic             resetn,       // Asynchronous reset, active low.
	input  wire logic             acc_start,    // Pulse: a new access session begins.
	input  wire logic             acc_remote,   // Session arrives over control channel.
	input  wire logic [1:0]       acc_port,     // Receive port carrying remote session.
	input  wire logic             reg_wr,       // Register write strobe.
	input  wire logic             reg_rd,       // Register read strobe.
	input  wire logic [7:0]       reg_addr,     // Register address.
	input  wire logic [7:0]       reg_wdata,    // Write data.
	output logic      [7:0]       reg_rdata,    // Read data, registered.
	output logic      [7:0]       paged_value,  // Selected port's paged register.
	input  wire logic [PORTS-1:0] crc_err_in,   // CRC error pulses per port.
	input  wire logic [PORTS-1:0] seq_err_in,   // Sequence error pulses per port.
	input  wire logic [PORTS-1:0] locked_in,    // Lock state per port (asynchronous).
	input  wire logic [PORTS-1:0] pass_in,      // Pass state per port (asynchronous).
	input  wire logic [PORTS-1:0] par_over_in,  // Parity count above threshold.
	input  wire logic [PORTS-1:0] par_count_clr // Parity count cleared pulse.
);
	// ****************************************************************
	// Synchronisers for the live link levels.
	// ****************************************************************
	logic [PORTS-1:0] lock_s1; // First stage, read by second stage only.
	logic [PORTS-1:0] lock_s2; // Synchronised lock.
	logic [PORTS-1:0] pass_s1; // First stage, read by second stage only.
	logic [PORTS-1:0] pass_s2; // Synchronised pass.

	// Two flops per level keep metastability out of the status logic.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lock_s1 <= '0;
			lock_s2 <= '0;
			pass_s1 <= '0;
			pass_s2 <= '0;
		end else begin
			lock_s1 <= locked_in;
			lock_s2 <= lock_s1;
			pass_s1 <= pass_in;
			pass_s2 <= pass_s1;
		end
	end

	// ****************************************************************
	// Port-select register.
	// ****************************************************************
	logic [1:0]       physical_port_number; // Port of the current session.
	logic [1:0]       read_port;            // Port chosen for readback.
	logic [PORTS-1:0] write_en;             // Per-port paged write enables.
	logic [1:0]       next_physical_port_number;
	logic [1:0]       next_read_port;
	logic [PORTS-1:0] next_write_en;

	// A session start reloads the defaults that depend on the access path.
	always_comb begin
		next_physical_port_number = physical_port_number;
		next_read_port            = read_port;
		next_write_en             = write_en;
		if (acc_start) begin
			next_physical_port_number = acc_remote ? acc_port : 2'h0;
			next_read_port            = acc_remote ? acc_port : 2'h0;
			next_write_en             = '0;
			if (acc_remote) begin
				next_write_en[acc_port] = 1'b1;
			end
		end else if (reg_wr && reg_addr == rpps_pkg::PAGE_SELECT_ADDR) begin
			// The physical port field is read-only; writes leave it alone.
			next_read_port = reg_wdata[rpps_pkg::READ_PORT_LSB +: 2];
			next_write_en  = reg_wdata[PORTS-1:0];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			physical_port_number <= 2'h0;
			read_port            <= 2'h0;
			write_en             <= '0;
		end else begin
			physical_port_number <= next_physical_port_number;
			read_port            <= next_read_port;
			write_en             <= next_write_en;
		end
	end

	// ****************************************************************
	// Paged registers and sticky status, one copy per port.
	// ****************************************************************
	logic [7:0] paged [PORTS];      // One paged register per port.
	logic [7:0] next_paged [PORTS];
	logic [PORTS-1:0] crc_flag;     // Sticky CRC errors.
	logic [PORTS-1:0] seq_flag;     // Sticky sequence errors.
	logic [PORTS-1:0] lchg_flag;    // Sticky lock changes.
	logic [PORTS-1:0] par_flag;     // Parity threshold flags.
	logic [PORTS-1:0] lock_prev;    // Lock state one cycle ago.
	logic [PORTS-1:0] next_crc_flag;
	logic [PORTS-1:0] next_seq_flag;
	logic [PORTS-1:0] next_lchg_flag;
	logic [PORTS-1:0] next_par_flag;
	logic             status_read;  // Read of the status register.

	assign status_read = reg_rd && reg_addr == rpps_pkg::STATUS_ONE_ADDR;

	// A status read clears only the selected port's flags; an event in the
	// same cycle as the read survives, because the set is applied last.
	genvar gi;
	generate
		for (gi = 0; gi < PORTS; gi++) begin : g_port
			always_comb begin
				logic clr;
				clr = status_read && read_port == 2'(gi);
				next_paged[gi] = paged[gi];
				if (reg_wr && reg_addr == rpps_pkg::PAGED_REG_ADDR && write_en[gi]) begin
					next_paged[gi] = reg_wdata;
				end
				next_crc_flag[gi]  = (crc_flag[gi] && !clr) || crc_err_in[gi];
				next_seq_flag[gi]  = (seq_flag[gi] && !clr) || seq_err_in[gi];
				next_lchg_flag[gi] = (lchg_flag[gi] && !clr)
					|| (lock_s2[gi] != lock_prev[gi]);
				// Over threshold sets and beats a read in the same cycle; a count
				// clear always wins, because the count has just gone to zero.
				next_par_flag[gi] = (par_flag[gi] && !clr && !par_count_clr[gi])
					|| (par_over_in[gi] && !par_count_clr[gi]);
			end

			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					paged[gi]     <= rpps_pkg::PAGED_RESET;
					crc_flag[gi]  <= 1'b0;
					seq_flag[gi]  <= 1'b0;
					lchg_flag[gi] <= 1'b0;
					par_flag[gi]  <= 1'b0;
					lock_prev[gi] <= 1'b0;
				end else begin
					paged[gi]     <= next_paged[gi];
					crc_flag[gi]  <= next_crc_flag[gi];
					seq_flag[gi]  <= next_seq_flag[gi];
					lchg_flag[gi] <= next_lchg_flag[gi];
					par_flag[gi]  <= next_par_flag[gi];
					lock_prev[gi] <= lock_s2[gi];
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Read-back mux.
	// ****************************************************************
	logic [7:0] status_word;      // Assembled status of the selected port.
	logic [7:0] next_reg_rdata;
	logic [7:0] next_paged_value;

	// The selected port drives every paged read, including the status word.
	always_comb begin
		status_word = rpps_pkg::STATUS_RESET;
		status_word[rpps_pkg::PHYS_PORT_LSB +: 2] = read_port;
		status_word[rpps_pkg::CRC_BIT]  = crc_flag[read_port];
		status_word[rpps_pkg::LCHG_BIT] = lchg_flag[read_port];
		status_word[rpps_pkg::SEQ_BIT]  = seq_flag[read_port];
		status_word[rpps_pkg::PAR_BIT]  = par_flag[read_port];
		status_word[rpps_pkg::PASS_BIT] = pass_s2[read_port];
		status_word[rpps_pkg::LOCK_BIT] = lock_s2[read_port];
		next_paged_value = paged[read_port];
		next_reg_rdata   = reg_rdata;
		if (reg_rd) begin
			case (reg_addr)
				rpps_pkg::PAGE_SELECT_ADDR: begin
					next_reg_rdata = {physical_port_number, read_port, write_en};
				end
				rpps_pkg::STATUS_ONE_ADDR: begin
					next_reg_rdata = status_word;
				end
				rpps_pkg::PAGED_REG_ADDR: begin
					next_reg_rdata = paged[read_port];
				end
				default: begin
					next_reg_rdata = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata   <= 8'h00;
			paged_value <= rpps_pkg::PAGED_RESET;
		end else begin
			reg_rdata   <= next_reg_rdata;
			paged_value <= next_paged_value;
		end
	end

	// ****************************************************************
	// Assertions.
	// ****************************************************************
	// Every property samples on the register clock and is held off while
	// reset is low, since every flop in this block is cleared then.

	// A remote session start: the step that reloads the path defaults.
	sequence remote_start_s;
		acc_start && acc_remote;
	endsequence

	// A local session start: defaults fall back to port 0 and no enables.
	sequence local_start_s;
		acc_start && !acc_remote;
	endsequence

	// A port-select write that no session start overrides.
	sequence select_write_s;
		reg_wr && !acc_start && reg_addr == rpps_pkg::PAGE_SELECT_ADDR;
	endsequence

	// A read of the status register: the step that clears sticky flags.
	sequence status_read_s;
		status_read;
	endsequence

	// Session defaults.
	remote_phys_a : assert property (@(posedge clk) disable iff (!resetn)
		remote_start_s |=> physical_port_number == $past(acc_port))
		else $error("physical port not loaded from arrival port");
	local_defaults_a : assert property (@(posedge clk) disable iff (!resetn)
		local_start_s |=> read_port == 2'h0 && write_en == '0)
		else $error("local defaults wrong");
	remote_wen_a : assert property (@(posedge clk) disable iff (!resetn)
		remote_start_s |=> write_en == (4'h1 << $past(acc_port)))
		else $error("remote write enable default wrong");

	// Host writes move the read port and enables, never the physical port.
	sel_write_a : assert property (@(posedge clk) disable iff (!resetn)
		select_write_s |=> read_port == $past(reg_wdata[rpps_pkg::READ_PORT_LSB +: 2])
			&& write_en == $past(reg_wdata[PORTS-1:0]))
		else $error("port select write not taken");
	phys_hold_a : assert property (@(posedge clk) disable iff (!resetn)
		select_write_s |=> $stable(physical_port_number))
		else $error("physical port changed by a write");

	// Paged copies: gated writes and readback from the selected port.
	paged_gate_a : assert property (@(posedge clk) disable iff (!resetn)
		reg_wr && !acc_start && reg_addr == rpps_pkg::PAGED_REG_ADDR && write_en == '0
		|=> $stable(paged[0]) && $stable(paged[3]))
		else $error("paged write not discarded");
	paged_write_a : assert property (@(posedge clk) disable iff (!resetn)
		reg_wr && reg_addr == rpps_pkg::PAGED_REG_ADDR && write_en[2]
		|=> paged[2] == $past(reg_wdata))
		else $error("enabled paged write lost");
	readback_sel_a : assert property (@(posedge clk) disable iff (!resetn)
		reg_rd && reg_addr == rpps_pkg::PAGED_REG_ADDR |=> reg_rdata == $past(paged[read_port]))
		else $error("paged readback from wrong port");

	// Status word: port field and the live levels of the selected port.
	status_port_a : assert property (@(posedge clk) disable iff (!resetn)
		status_read_s |=> reg_rdata[7:6] == $past(read_port))
		else $error("status port field wrong");
	live_lock_a : assert property (@(posedge clk) disable iff (!resetn)
		status_read_s |=> reg_rdata[0] == $past(lock_s2[read_port])
			&& reg_rdata[1] == $past(pass_s2[read_port]))
		else $error("live lock or pass bit wrong");

	// Sticky flags: an event always sets its flag, and a read of the selected
	// port clears it only when no event lands in the same cycle.
	crc_sticky_a : assert property (@(posedge clk) disable iff (!resetn)
		(|crc_err_in) |=> (~crc_flag & $past(crc_err_in)) == '0)
		else $error("crc flag not set");
	crc_clear_a : assert property (@(posedge clk) disable iff (!resetn)
		status_read_s |=> !crc_flag[$past(read_port)] || $past(crc_err_in[read_port]))
		else $error("crc flag not cleared by read");
	seq_set_a : assert property (@(posedge clk) disable iff (!resetn)
		(|seq_err_in) |=> (~seq_flag & $past(seq_err_in)) == '0)
		else $error("sequence flag not set");
	seq_clear_a : assert property (@(posedge clk) disable iff (!resetn)
		status_read_s |=> !seq_flag[$past(read_port)] || $past(seq_err_in[read_port]))
		else $error("sequence flag not cleared by read");
	lock_chg_a : assert property (@(posedge clk) disable iff (!resetn)
		(lock_s2 != lock_prev) |=> (~lchg_flag & $past(lock_s2 ^ lock_prev)) == '0)
		else $error("lock change not flagged");
	lchg_clear_a : assert property (@(posedge clk) disable iff (!resetn)
		status_read_s |=> !lchg_flag[$past(read_port)]
			|| $past(lock_s2[read_port] != lock_prev[read_port]))
		else $error("lock change flag not cleared by read");

	// Parity flag: over threshold sets it, a count clear or a read clears it.
	par_set_a : assert property (@(posedge clk) disable iff (!resetn)
		(|(par_over_in & ~par_count_clr))
		|=> (~par_flag & $past(par_over_in & ~par_count_clr)) == '0)
		else $error("parity flag not set over threshold");
	par_clear_a : assert property (@(posedge clk) disable iff (!resetn)
		(|par_count_clr) |=> (par_flag & $past(par_count_clr)) == '0)
		else $error("parity flag not cleared");
	par_read_a : assert property (@(posedge clk) disable iff (!resetn)
		status_read_s |=> !par_flag[$past(read_port)] || $past(par_over_in[read_port]))
		else $error("parity flag not cleared by read");
endmodule : rpps_top

`default_nettype wire

// >>> sim/rpps_host_model.sv
// Host-side model that opens access sessions and issues register cycles.
`timescale 1ns/1ps
`default_nettype none

module rpps_host_model (
	input  wire logic       clk,        // Register clock.
	output logic            acc_start,  // Session start pulse.
	output logic            acc_remote, // Session path, 1 for control channel.
	output logic      [1:0] acc_port,   // Arrival port of a remote session.
	output logic            reg_wr,     // Write strobe.
	output logic            reg_rd,     // Read strobe.
	output logic      [7:0] reg_addr,   // Register address.
	output logic      [7:0] reg_wdata,  // Write data.
	input  wire logic [7:0] reg_rdata   // Registered read data.
);
	// ****************************************************************
	// Bus cycles.
	// ****************************************************************
	// Everything idles low from time zero so no strobe fires during reset.
	initial begin
		{acc_start, acc_remote, acc_port, reg_wr, reg_rd} = '0;
		reg_addr  = 8'h00;
		reg_wdata = 8'h00;
	end

	// A session start loads the path defaults of the register block.
	task automatic session(input logic remote, input logic [1:0] port);
		@(posedge clk) begin
			acc_start  <= 1'b1;
			acc_remote <= remote;
			acc_port   <= port;
		end
		@(posedge clk) acc_start <= 1'b0;
	endtask : session

	// One-cycle write strobe; the next cycle follows after one idle clock.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) begin
			reg_wr    <= 1'b1;
			reg_addr  <= a;
			reg_wdata <= d;
		end
		@(posedge clk) reg_wr <= 1'b0;
	endtask : wr

	// Data is taken one cycle after the strobe edge, once it has settled.
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk) begin
			reg_rd   <= 1'b1;
			reg_addr <= a;
		end
		@(posedge clk) reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
endmodule : rpps_host_model

`default_nettype wire

// >>> sim/rx_port_page_select_status_tb.sv
// Self-checking testbench of the port page select and status bank.
`timescale 1ns/1ps
`default_nettype none

module rx_port_page_select_status_tb;
	// ****************************************************************
	// Signals.
	// ****************************************************************
	logic       clk, resetn;             // Clock and reset.
	logic       acc_start, acc_remote;   // Session controls.
	logic [1:0] acc_port;                // Arrival port.
	logic       reg_wr, reg_rd;          // Strobes.
	logic [7:0] reg_addr, reg_wdata;     // Address and data.
	logic [7:0] reg_rdata, paged_value;  // Design outputs.
	logic [3:0] crc_err_in, seq_err_in;  // Event pulses.
	logic [3:0] locked_in, pass_in;      // Live levels.
	logic [3:0] par_over_in, par_count_clr; // Parity inputs.
	int         err_total, compares, cycles; // Counters.
	localparam logic [7:0] SEL = rpps_pkg::PAGE_SELECT_ADDR; // Short names.
	localparam logic [7:0] STS = rpps_pkg::STATUS_ONE_ADDR;
	localparam logic [7:0] PG  = rpps_pkg::PAGED_REG_ADDR;

	rpps_top DUT (.clk(clk), .resetn(resetn), .acc_start(acc_start), .acc_remote(acc_remote),
		.acc_port(acc_port), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .paged_value(paged_value),
		.crc_err_in(crc_err_in), .seq_err_in(seq_err_in), .locked_in(locked_in),
		.pass_in(pass_in), .par_over_in(par_over_in), .par_count_clr(par_count_clr));

	rpps_host_model host (.clk(clk), .acc_start(acc_start), .acc_remote(acc_remote),
		.acc_port(acc_port), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

	// ****************************************************************
	// Clock, timeout and shared tasks.
	// ****************************************************************
	// The clock runs at 40 MHz.
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// The tests need under a hundred cycles, so 3000 means a hang.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_total++;
			final_report();
		end
	end

	// Compares one value and reports a mismatch at once.
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	// Reads a register and compares it.
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		host.rd(a, v);
		check(v, exp);
	endtask : rdchk

	// Prints the counts and the verdict, then ends the run.
	task automatic final_report();
		$display("errors=%0d compares=%0d", err_total, compares);
		if (err_total == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : final_report

	// ****************************************************************
	// Scenarios.
	// ****************************************************************
	// A remote session over port 2 loads its defaults; a local one clears them.
	task automatic sc_sessions();
		host.session(1'b1, 2'd2);
		rdchk(SEL, 8'ha4);
		rdchk(STS, 8'h80);
		host.session(1'b0, 2'd3);
		rdchk(SEL, 8'h00);
	endtask : sc_sessions

	// Writes through two enables, reads pages 0 to 2, then a write with none.
	task automatic sc_paged();
		host.wr(SEL, 8'h05);
		host.wr(PG, 8'h3c);
		rdchk(PG, 8'h3c);
		host.wr(SEL, 8'h15);
		rdchk(PG, 8'h00);
		host.wr(SEL, 8'h20);
		host.wr(PG, 8'h77);
		rdchk(PG, 8'h3c);
		check(paged_value, 8'h3c);
		rdchk(SEL, 8'h20);
		host.wr(STS, 8'hff);
		rdchk(STS, 8'h80);
	endtask : sc_paged

	// Control channel errors stick until a read of their own port clears them;
	// an error that lands in the very cycle of the read survives that read.
	task automatic sc_sticky();
		logic [7:0] v;
		host.wr(SEL, 8'h10);
		@(posedge clk) {crc_err_in, seq_err_in} <= 8'ha2;
		@(posedge clk) {crc_err_in, seq_err_in} <= 8'h00;
		rdchk(STS, 8'h68);
		rdchk(STS, 8'h40);
		host.wr(SEL, 8'h30);
		rdchk(STS, 8'he0);
		rdchk(STS, 8'hc0);
		host.wr(SEL, 8'h10);
		fork
			host.rd(STS, v);
			begin
				@(posedge clk) seq_err_in <= 4'h2;
				@(posedge clk) seq_err_in <= 4'h0;
			end
		join
		check(v, 8'h40);
		rdchk(STS, 8'h48);
		rdchk(STS, 8'h40);
	endtask : sc_sticky

	// Lock and pass rise; the change flag latches, the levels stay live.
	task automatic sc_live();
		@(posedge clk) {locked_in, pass_in} <= 8'h22;
		repeat (5) @(posedge clk);
		rdchk(STS, 8'h53);
		rdchk(STS, 8'h43);
	endtask : sc_live

	// Parity flag sets over threshold, clears by read and by count clear.
	task automatic sc_parity();
		@(posedge clk) par_over_in <= 4'h2;
		@(posedge clk) par_over_in <= 4'h0;
		rdchk(STS, 8'h47);
		rdchk(STS, 8'h43);
		@(posedge clk) par_over_in <= 4'h2;
		@(posedge clk) begin
			par_over_in   <= 4'h0;
			par_count_clr <= 4'h2;
		end
		@(posedge clk) par_count_clr <= 4'h0;
		rdchk(STS, 8'h43);
	endtask : sc_parity

	// ****************************************************************
	// Main sequence.
	// ****************************************************************
	// Reset is held for 8 cycles before the first access.
	initial begin
		{err_total, compares, cycles} = '0;
		resetn = 1'b0;
		{crc_err_in, seq_err_in, locked_in, pass_in, par_over_in, par_count_clr} = '0;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		rdchk(SEL, 8'h00);
		rdchk(STS, rpps_pkg::STATUS_RESET);
		sc_sessions();
		sc_paged();
		sc_sticky();
		sc_live();
		sc_parity();
		final_report();
	end
endmodule : rx_port_page_select_status_tb

`default_nettype wire
